// ===== src/ssw_pkg.sv
/*
 * Shared constants and types for the four-wire serial link with a two-way
 * select line: timing figures, idle levels, widths and the slave states.
 * Assumes a 50 MHz core clock on both ends.
 */
package ssw_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 16;
    // resume_wait_time: least time, rounded up
    localparam int RESUME_WAIT_NS = 2000;
    localparam int RESUME_WAIT_CYC = (RESUME_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // access_request_window: longest time, rounded down
    localparam int ACCESS_REQUEST_WINDOW_NS = 1000;
    localparam int ACCESS_REQUEST_WINDOW_CYC = ACCESS_REQUEST_WINDOW_NS / CLK_PERIOD_NS;
    // cycles the slave ignores the select line after releasing it
    localparam int GUARD_CYC = 6;
    // half period of the clock the master makes, in core cycles
    localparam int SCLK_HALF_CYC = 8;
    localparam logic [CNT_W-1:0] RESUME_CNT = CNT_W'(RESUME_WAIT_CYC);
    localparam logic [CNT_W-1:0] WINDOW_CNT = CNT_W'(ACCESS_REQUEST_WINDOW_CYC);
    localparam logic [CNT_W-1:0] GUARD_CNT = CNT_W'(GUARD_CYC);
    localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(SCLK_HALF_CYC);
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int MSB = BYTE_W - 1;
    // select is active low; mode 0 idles clock and data low
    localparam logic SEL_ON = 1'h0;
    localparam logic SEL_OFF = 1'h1;
    localparam logic IDLE_LVL = 1'h0;
    // synchroniser lanes: 0 select, 1 clock, 2 data; reset to idle levels
    localparam logic [2:0] SYNC_IDLE = 3'h1;
    localparam int LANE_SEL = 0;
    localparam int LANE_CLK = 1;
    localparam int LANE_DAT = 2;
    typedef enum logic [2:0] {
        ST_INIT,
        ST_DESEL,
        ST_SEL,
        ST_BUSY,
        ST_PROACT,
        ST_SAVE
    } ssw_slave_state_t;
endpackage

// ===== src/ssw_link_if.sv
/*
 * The shared wires between master and slave, with one modport for each end.
 * Assumes pull-ups on select and master-in data; the line levels are
 * resolved here from the drivers' values and enables.
 */
interface ssw_link_if;
    logic nss_m_o;
    logic nss_m_oe;
    logic nss_s_o;
    logic nss_s_oe;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic nss_line;
    logic miso_line;

    // wired-and of the select drivers, pulled high when nobody drives
    assign nss_line = ~((nss_m_oe & ~nss_m_o) | (nss_s_oe & ~nss_s_o));
    assign miso_line = miso_oe ? miso_o : 1'h1;

    modport master (
        output nss_m_o,
        output nss_m_oe,
        output sclk,
        output mosi,
        input nss_line,
        input miso_line
    );
    modport slave (
        output nss_s_o,
        output nss_s_oe,
        output miso_o,
        output miso_oe,
        input nss_line,
        input sclk,
        input mosi
    );
endinterface

// ===== src/ssw_slave.sv
/*
 * Slave end of the four-wire link: pin ownership per state, a mode 0 byte
 * shifter, busy and access-request driving of the select line, power saving.
 * Assumes the link pins are asynchronous to CORE_CLK and the master keeps
 * its own duties on the shared lines.
 */
module ssw_slave
    import ssw_pkg::*;
(
    // clocking
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    // link
    ssw_link_if.slave LINK,
    // user data
    input wire logic [BYTE_W-1:0] TX_DATA,
    output logic [BYTE_W-1:0] RX_DATA,
    output logic RX_VALID,
    // user control
    input wire logic BUSY_REQ,
    input wire logic ACCESS_REQ,
    input wire logic SLEEP_REQ,
    // status
    output ssw_slave_state_t STATE,
    output logic NSS_S_O,
    output logic NSS_S_OE,
    output logic MISO_O,
    output logic MISO_OE
);
    logic [2:0] raw;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] filt;
    logic [2:0] filt_prev;
    logic sclk_rise;
    logic sclk_fall;
    logic line_low;
    ssw_slave_state_t state;
    logic [CNT_W-1:0] win_cnt;
    logic [CNT_W-1:0] guard;
    logic [2:0] bit_cnt;
    logic [BYTE_W-1:0] rx_shift;
    logic [BYTE_W-1:0] tx_shift;
    logic xfer_done;
    logic own_drive;

    // a change counts once the second and third stage agree
    function automatic logic settle(input logic prev, input logic s2, input logic s3);
        settle = (s2 == s3) ? s3 : prev;
    endfunction

    assign raw = {LINK.mosi, LINK.sclk, LINK.nss_line};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge CORE_CLK) begin
                if (RST) begin
                    sync1[i] <= SYNC_IDLE[i];
                    sync2[i] <= SYNC_IDLE[i];
                    sync3[i] <= SYNC_IDLE[i];
                    filt[i] <= SYNC_IDLE[i];
                    filt_prev[i] <= SYNC_IDLE[i];
                end else if (CE) begin
                    sync1[i] <= raw[i];
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                    filt[i] <= settle(filt[i], sync2[i], sync3[i]);
                    filt_prev[i] <= filt[i];
                end
            end
        end
    endgenerate

    assign sclk_rise = filt[LANE_CLK] & ~filt_prev[LANE_CLK];
    assign sclk_fall = ~filt[LANE_CLK] & filt_prev[LANE_CLK];
    // select seen low from the master, our own drive masked by the guard
    assign line_low = (filt[LANE_SEL] == SEL_ON) && (guard == '0);
    assign own_drive = (state == ST_BUSY) || (state == ST_PROACT);

    // guard against reading back our own assertion through the synchroniser
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            guard <= '0;
        end else if (CE) begin
            if (own_drive) begin
                guard <= GUARD_CNT;
            end else if (guard != '0) begin
                guard <= guard - CNT_W'(1);
            end
        end
    end

    // slave state machine
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state <= ST_INIT;
            win_cnt <= '0;
        end else if (CE) begin
            unique case (state)
                ST_INIT: begin
                    if (filt[LANE_SEL] == SEL_OFF) begin
                        state <= ST_DESEL;
                    end
                end
                ST_DESEL: begin
                    if (line_low) begin
                        state <= ST_SEL;
                    end else if (ACCESS_REQ) begin
                        state <= ST_PROACT;
                        win_cnt <= '0;
                    end else if (SLEEP_REQ) begin
                        state <= ST_SAVE;
                    end
                end
                ST_SEL: begin
                    if (filt[LANE_SEL] == SEL_OFF) begin
                        if (xfer_done && BUSY_REQ) begin
                            state <= ST_BUSY;
                        end else begin
                            state <= ST_DESEL;
                        end
                    end
                end
                ST_BUSY: begin
                    if (!BUSY_REQ) begin
                        state <= ST_DESEL;
                    end
                end
                ST_PROACT: begin
                    // release at the window's end; a held line then selects us
                    if (win_cnt >= WINDOW_CNT - CNT_W'(1)) begin
                        state <= ST_DESEL;
                    end else begin
                        win_cnt <= win_cnt + CNT_W'(1);
                    end
                end
                ST_SAVE: begin
                    if (line_low) begin
                        state <= ST_SEL;
                    end else if (!SLEEP_REQ) begin
                        state <= ST_DESEL;
                    end
                end
            endcase
        end
    end

    // mode 0 shifter: sample on rising clock, shift out on falling clock
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            bit_cnt <= '0;
            rx_shift <= '0;
            tx_shift <= '0;
            xfer_done <= 1'h0;
            RX_DATA <= '0;
            RX_VALID <= 1'h0;
        end else if (CE) begin
            RX_VALID <= 1'h0;
            if (state != ST_SEL) begin
                bit_cnt <= '0;
                tx_shift <= TX_DATA;
                if (state != ST_BUSY) begin
                    xfer_done <= 1'h0;
                end
            end else if (sclk_rise) begin
                rx_shift <= {rx_shift[MSB-1:0], filt[LANE_DAT]};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == LAST_BIT) begin
                    RX_DATA <= {rx_shift[MSB-1:0], filt[LANE_DAT]};
                    RX_VALID <= 1'h1;
                    xfer_done <= 1'h1;
                end
            end else if (sclk_fall) begin
                if (bit_cnt == '0) begin
                    tx_shift <= TX_DATA;
                end else begin
                    tx_shift <= {tx_shift[MSB-1:0], 1'h0};
                end
            end
        end
    end

    // pin ownership per state, each pin registered
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            NSS_S_O <= SEL_OFF;
            NSS_S_OE <= 1'h0;
            MISO_O <= IDLE_LVL;
            MISO_OE <= 1'h0;
        end else if (CE) begin
            NSS_S_O <= own_drive ? SEL_ON : SEL_OFF;
            NSS_S_OE <= own_drive;
            MISO_O <= tx_shift[MSB];
            MISO_OE <= (state == ST_SEL) || (state == ST_BUSY);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            STATE <= ST_INIT;
        end else if (CE) begin
            STATE <= state;
        end
    end

    assign LINK.nss_s_o = NSS_S_O;
    assign LINK.nss_s_oe = NSS_S_OE;
    assign LINK.miso_o = MISO_O;
    assign LINK.miso_oe = MISO_OE;
endmodule

// ===== src/ssw_master.sv
/*
 * Master end of the four-wire link: makes the link clock by division,
 * checks the select line is free, asserts it, waits the resume time and
 * moves one byte in mode 0. Assumes one slave on this select line.
 */
module ssw_master
    import ssw_pkg::*;
(
    // clocking
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    // link
    ssw_link_if.master LINK,
    // user request
    input wire logic START,
    input wire logic [BYTE_W-1:0] TX_DATA,
    // user answer
    output logic [BYTE_W-1:0] RX_DATA,
    output logic DONE,
    output logic SLAVE_ASSERT,
    output logic ACTIVE
);
    typedef enum logic [2:0] {
        M_IDLE,
        M_CHECK,
        M_WAIT,
        M_XFER,
        M_END
    } ssw_master_state_t;

    ssw_master_state_t state;
    logic [1:0] raw;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] filt;
    logic [CNT_W-1:0] cnt;
    logic [2:0] bit_cnt;
    logic [BYTE_W-1:0] tx_shift;
    logic [BYTE_W-1:0] rx_shift;
    logic nss_o;
    logic nss_oe;
    logic sclk;
    logic mosi;

    function automatic logic settle(input logic prev, input logic s2, input logic s3);
        settle = (s2 == s3) ? s3 : prev;
    endfunction

    assign raw = {LINK.miso_line, LINK.nss_line};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_sync
            always_ff @(posedge CORE_CLK) begin
                if (RST) begin
                    sync1[i] <= 1'h1;
                    sync2[i] <= 1'h1;
                    sync3[i] <= 1'h1;
                    filt[i] <= 1'h1;
                end else if (CE) begin
                    sync1[i] <= raw[i];
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                    filt[i] <= settle(filt[i], sync2[i], sync3[i]);
                end
            end
        end
    endgenerate

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state <= M_IDLE;
            cnt <= '0;
            bit_cnt <= '0;
            tx_shift <= '0;
            rx_shift <= '0;
            nss_o <= SEL_OFF;
            nss_oe <= 1'h0;
            sclk <= IDLE_LVL;
            mosi <= IDLE_LVL;
            RX_DATA <= '0;
            DONE <= 1'h0;
        end else if (CE) begin
            DONE <= 1'h0;
            unique case (state)
                M_IDLE: begin
                    sclk <= IDLE_LVL;
                    mosi <= IDLE_LVL;
                    nss_oe <= 1'h0;
                    if (START) begin
                        tx_shift <= TX_DATA;
                        state <= M_CHECK;
                    end
                end
                M_CHECK: begin
                    // a slave holding select keeps our own select unenforced
                    if (filt[0] == SEL_OFF) begin
                        nss_o <= SEL_ON;
                        nss_oe <= 1'h1;
                        cnt <= '0;
                        state <= M_WAIT;
                    end
                end
                M_WAIT: begin
                    if (cnt >= RESUME_CNT - CNT_W'(1)) begin
                        cnt <= '0;
                        bit_cnt <= '0;
                        mosi <= tx_shift[MSB];
                        state <= M_XFER;
                    end else begin
                        cnt <= cnt + CNT_W'(1);
                    end
                end
                M_XFER: begin
                    if (cnt >= HALF_CNT - CNT_W'(1)) begin
                        cnt <= '0;
                        sclk <= ~sclk;
                        if (sclk) begin
                            // sample at the end of the high phase, then shift
                            rx_shift <= {rx_shift[MSB-1:0], filt[1]};
                            tx_shift <= {tx_shift[MSB-1:0], 1'h0};
                            mosi <= tx_shift[MSB-1];
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == LAST_BIT) begin
                                RX_DATA <= {rx_shift[MSB-1:0], filt[1]};
                                mosi <= IDLE_LVL;
                                state <= M_END;
                            end
                        end
                    end else begin
                        cnt <= cnt + CNT_W'(1);
                    end
                end
                M_END: begin
                    nss_o <= SEL_OFF;
                    nss_oe <= 1'h0;
                    DONE <= 1'h1;
                    state <= M_IDLE;
                end
                default: begin
                    state <= M_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            SLAVE_ASSERT <= 1'h0;
            ACTIVE <= 1'h0;
        end else if (CE) begin
            SLAVE_ASSERT <= (filt[0] == SEL_ON) && !nss_oe;
            ACTIVE <= (state != M_IDLE);
        end
    end

    assign LINK.nss_m_o = nss_o;
    assign LINK.nss_m_oe = nss_oe;
    assign LINK.sclk = sclk;
    assign LINK.mosi = mosi;
endmodule

// ===== verification/ssw_checker.sv
/*
 * Concurrent checks on the shared wires of the four-wire link.
 * Assumes it is instantiated beside the link interface, fed its signals.
 */
module ssw_checker
    import ssw_pkg::*;
(
    // clocking
    input wire logic CORE_CLK,
    input wire logic RST,
    // link
    input wire logic nss_m_o,
    input wire logic nss_m_oe,
    input wire logic nss_s_o,
    input wire logic nss_s_oe,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic nss_line,
    input wire logic miso_line
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // a slave drive that starts after this long an idle line is a request
    localparam logic [CNT_W-1:0] HI_LONG = 16'h0014;
    logic [CNT_W-1:0] sel_cnt;
    logic [CNT_W-1:0] hi_cnt;
    logic [CNT_W-1:0] drv_cnt;
    logic [3:0] bits;
    logic sclk_d;
    logic proact;

    always_ff @(posedge CORE_CLK) begin
        if (RST || !nss_m_oe) sel_cnt <= '0;
        else if (sel_cnt != '1) sel_cnt <= sel_cnt + 16'h0001;
    end
    always_ff @(posedge CORE_CLK) begin
        if (RST || !nss_line) hi_cnt <= '0;
        else if (hi_cnt != '1) hi_cnt <= hi_cnt + 16'h0001;
    end
    always_ff @(posedge CORE_CLK) begin
        if (RST || !nss_s_oe) drv_cnt <= '0;
        else if (drv_cnt != '1) drv_cnt <= drv_cnt + 16'h0001;
    end
    // bits clocked in the current selection by the master
    always_ff @(posedge CORE_CLK) begin
        sclk_d <= sclk;
        if (RST || $rose(nss_m_oe)) bits <= 4'h0;
        else if (sclk && !sclk_d && bits != 4'hF) bits <= bits + 4'h1;
    end
    always_ff @(posedge CORE_CLK) begin
        if (RST || !nss_s_oe) proact <= 1'h0;
        else if (drv_cnt == '0 && hi_cnt >= HI_LONG) proact <= 1'h1;
    end

    property p_init_off;
        $fell(RST) |-> !nss_s_oe && !miso_oe && !nss_m_oe;
    endproperty
    a_init_off: assert property (p_init_off) else $error("drivers on after reset");
    property p_sel_low;
        nss_s_oe |-> nss_s_o == SEL_ON;
    endproperty
    a_sel_low: assert property (p_sel_low) else $error("slave drives select high");
    property p_miso_hiz;
        nss_line [*8] |-> !miso_oe;
    endproperty
    a_miso_hiz: assert property (p_miso_hiz) else $error("miso driven while deselected");
    property p_idle_lines;
        (!nss_m_oe) [*2] |-> sclk == IDLE_LVL && mosi == IDLE_LVL;
    endproperty
    a_idle_lines: assert property (p_idle_lines) else $error("clock or data not idle");
    property p_resume;
        $rose(sclk) |-> sel_cnt >= RESUME_CNT;
    endproperty
    a_resume: assert property (p_resume) else $error("clock before resume wait");
    property p_yield;
        nss_s_oe [*6] |-> !$rose(nss_m_oe);
    endproperty
    a_yield: assert property (p_yield) else $error("master drives over slave");
    property p_busy_after_byte;
        $rose(nss_s_oe) && hi_cnt < HI_LONG |-> bits >= 4'h8;
    endproperty
    a_busy_after_byte: assert property (p_busy_after_byte) else $error("busy without byte");
    property p_proact_len;
        proact |-> drv_cnt <= WINDOW_CNT + 16'h0001;
    endproperty
    a_proact_len: assert property (p_proact_len) else $error("request too long");
    property p_proact_miso;
        proact |-> !miso_oe;
    endproperty
    a_proact_miso: assert property (p_proact_miso) else $error("miso on in request");

    c_proact: cover property ($rose(proact));
    c_busy: cover property ($rose(nss_s_oe) && hi_cnt < HI_LONG);
    c_clock: cover property ($rose(sclk));
endmodule

// ===== verification/tb_top.sv
/*
 * Testbench joining master and slave ends through the link interface.
 * Assumes the link clock is made by the master; inputs change at negedge.
 */
module tb_top
    import ssw_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic m_start = 1'h0;
    logic [7:0] m_tx = 8'h00;
    logic [7:0] m_rx;
    logic m_done, m_slave_assert, m_active;
    logic [7:0] s_tx = 8'h00;
    logic [7:0] s_rx;
    logic s_rx_valid, s_nss_o, s_nss_oe, s_miso_o, s_miso_oe;
    logic busy_req = 1'h0;
    logic access_req = 1'h0;
    logic sleep_req = 1'h0;
    ssw_slave_state_t s_state;
    logic [7:0] mosi_sh, miso_sh;
    int n_errors = 0;
    int tests_run = 0;
    int n_rx = 0;
    int n_xfer = 0;

    ssw_link_if link();
    ssw_master u_ssw_master (.CORE_CLK(core_clk), .RST(rst), .CE(1'h1), .LINK(link),
        .START(m_start), .TX_DATA(m_tx), .RX_DATA(m_rx), .DONE(m_done),
        .SLAVE_ASSERT(m_slave_assert), .ACTIVE(m_active));
    ssw_slave u_ssw_slave (.CORE_CLK(core_clk), .RST(rst), .CE(1'h1), .LINK(link),
        .TX_DATA(s_tx), .RX_DATA(s_rx), .RX_VALID(s_rx_valid), .BUSY_REQ(busy_req),
        .ACCESS_REQ(access_req), .SLEEP_REQ(sleep_req), .STATE(s_state),
        .NSS_S_O(s_nss_o), .NSS_S_OE(s_nss_oe), .MISO_O(s_miso_o), .MISO_OE(s_miso_oe));
    ssw_checker u_ssw_checker (.CORE_CLK(core_clk), .RST(rst), .nss_m_o(link.nss_m_o),
        .nss_m_oe(link.nss_m_oe), .nss_s_o(link.nss_s_o), .nss_s_oe(link.nss_s_oe),
        .sclk(link.sclk), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
        .nss_line(link.nss_line), .miso_line(link.miso_line));

    always #10 core_clk = ~core_clk;
    // received-byte strobes seen from the slave
    always @(posedge core_clk) begin
        if (s_rx_valid === 1'h1) n_rx++;
    end
    // wire bits as seen at each rising link clock
    always @(posedge link.sclk) begin
        mosi_sh <= {mosi_sh[6:0], link.mosi};
        miso_sh <= {miso_sh[6:0], link.miso_line};
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic start(input logic [7:0] tm, input logic [7:0] ts);
        @(negedge core_clk);
        m_start = 1'h1;
        m_tx = tm;
        s_tx = ts;
        @(negedge core_clk);
        m_start = 1'h0;
    endtask
    task automatic finish(input logic [7:0] tm, input logic [7:0] ts);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge core_clk);
            #1;
            if (m_done === 1'h1) break;
        end
        check(8'(m_done), 8'h01);
        tick(12);
        n_xfer++;
        check(8'(n_rx), 8'(n_xfer));
        check(m_rx, ts);
        check(s_rx, tm);
        check(mosi_sh, tm);
        check(miso_sh, ts);
    endtask
    task automatic t_reset();
        tick(3);
        rst = 1'h0;
        check(8'(s_state), 8'(ST_INIT));
        check({6'h00, s_nss_oe, s_miso_oe}, 8'h00);
        check(8'(m_active), 8'h00);
        tick(20);
        check(8'(s_state), 8'(ST_DESEL));
        check({6'h00, s_nss_oe, s_miso_oe}, 8'h00);
    endtask
    task automatic t_busy();
        busy_req = 1'h1;
        start(8'hC3, 8'h5A);
        finish(8'hC3, 8'h5A);
        check(8'(s_state), 8'(ST_BUSY));
        check({6'h00, m_slave_assert, s_nss_oe}, 8'h03);
        check(8'(s_nss_o), 8'(SEL_ON));
        start(8'h0F, 8'hF0);
        tick(200);
        check({6'h00, m_active, link.nss_m_oe}, 8'h02);
        busy_req = 1'h0;
        finish(8'h0F, 8'hF0);
    endtask
    task automatic t_proact();
        access_req = 1'h1;
        tick(1);
        access_req = 1'h0;
        tick(8);
        check(8'(s_state), 8'(ST_PROACT));
        check({6'h00, m_slave_assert, s_miso_oe}, 8'h02);
        tick(60);
        check(8'(s_state), 8'(ST_DESEL));
        check(8'(s_nss_oe), 8'h00);
    endtask
    task automatic t_clash();
        // the request must reach the master's synchroniser before its check
        access_req = 1'h1;
        tick(1);
        access_req = 1'h0;
        tick(6);
        start(8'h96, 8'h69);
        tick(20);
        check(8'(link.nss_m_oe), 8'h00);
        check(8'(m_active), 8'h01);
        finish(8'h96, 8'h69);
    endtask
    task automatic t_sleep();
        sleep_req = 1'h1;
        tick(5);
        check(8'(s_state), 8'(ST_SAVE));
        check(8'(s_miso_oe), 8'h00);
        start(8'h3E, 8'hE3);
        finish(8'h3E, 8'hE3);
        sleep_req = 1'h0;
        tick(10);
    endtask

    initial begin
        #800000;
        n_errors++;
        $display("FAIL %0t: watchdog expired", $time);
        wrap_up();
    end
    initial begin
        t_reset();
        start(8'hA5, 8'h3C);
        finish(8'hA5, 8'h3C);
        start(8'hFF, 8'h00);
        finish(8'hFF, 8'h00);
        t_busy();
        t_proact();
        t_clash();
        t_sleep();
        wrap_up();
    end
endmodule
